// ---- hw/slpd_regs.sv ----
// Register bank for link PLL control and lane 3 output emphasis.
// Assumes a synchronous host port; the lock-lost input comes from another clock.
//
// Operation
// R01: Lane 3 emphasis bits [6:4], codes 0-3.
// R02: Writing 0x04 at 0x1222 holds calibration reset.
// R03: Writing 0x4F at 0x1228 resets start-up circuit.
// R04: Writing 0x80 at 0x1262 clears lock-lost flag.
// R05: Host restores normal value after each command.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module slpd_regs
	import slpd_pkg::*;
(
	// Clock and reset
	input  wire logic            i_clock,
	input  wire logic            i_reset,
	// Register port
	input  wire slpd_bus_t       i_bus,
	output logic [7:0]           o_read_data,
	// PLL side
	input  wire logic            i_pll_lock_lost,
	output var slpd_pll_ctrl_t   o_pll_ctrl,
	output logic                 o_pll_lock_lost_flag,
	// Interrupt
	output logic                 o_irq
);

	////////////////////////////////////////////////////////////////////////
	// Lock-lost input synchroniser and edge detect

	logic sync_stage1;
	logic sync_stage2;
	logic sync_prev;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			sync_stage1 <= 1'b0;
			sync_stage2 <= 1'b0;
			sync_prev   <= 1'b0;
		end else begin
			sync_stage1 <= i_pll_lock_lost;
			sync_stage2 <= sync_stage1;
			sync_prev   <= sync_stage2;
		end
	end

	wire logic lock_lost_event = sync_stage2 & ~sync_prev;

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]           calibration;
	logic [7:0]           startup;
	logic [7:0]           lock_loss;
	logic [7:0]           emphasis;
	logic                 lock_lost_flag;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_enable;
	logic [7:0]           read_data;

	logic [7:0]           next_calibration;
	logic [7:0]           next_startup;
	logic [7:0]           next_lock_loss;
	logic [7:0]           next_emphasis;
	logic                 next_lock_lost_flag;
	logic [IRQ_WIDTH-1:0] next_irq_status;
	logic [IRQ_WIDTH-1:0] next_irq_enable;
	logic [7:0]           next_read_data;

	// Write strobe aimed at one register
	function automatic logic hit(input slpd_bus_t bus, input logic [15:0] addr);
		hit = bus.write_strobe && (bus.address == addr);
	endfunction

	// Write of one exact command value to one register
	function automatic logic cmd_hit(
		input slpd_bus_t   bus,
		input logic [15:0] addr,
		input logic [7:0]  value
	);
		cmd_hit = hit(bus, addr) && (bus.write_data == value);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Control registers

	// Values are stored as written, IRQ enable only its low two bits; only exact commands set the PLL reset and clear bits
	always_comb begin
		next_calibration = calibration;
		next_startup     = startup;
		next_lock_loss   = lock_loss;
		next_emphasis    = emphasis;
		next_irq_enable  = irq_enable;
		if (hit(i_bus, LINK_PLL_CALIBRATION_ADDR)) begin
			next_calibration = i_bus.write_data; // [R02]
		end
		if (hit(i_bus, LINK_PLL_STARTUP_ADDR)) begin
			next_startup = i_bus.write_data; // [R03]
		end
		if (hit(i_bus, LINK_PLL_LOCK_LOSS_ADDR)) begin
			next_lock_loss = i_bus.write_data; // [R04]
		end
		if (hit(i_bus, LANE3_EMPHASIS_ADDR)) begin
			next_emphasis = i_bus.write_data; // [R01]
		end
		if (hit(i_bus, IRQ_ENABLE_ADDR)) begin
			next_irq_enable = i_bus.write_data[IRQ_WIDTH-1:0];
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			calibration <= LINK_PLL_CALIBRATION_RESET;
			startup     <= LINK_PLL_STARTUP_RESET;
			lock_loss   <= LINK_PLL_LOCK_LOSS_RESET;
			emphasis    <= LANE3_EMPHASIS_RESET;
			irq_enable  <= '0;
		end else begin
			calibration <= next_calibration;
			startup     <= next_startup;
			lock_loss   <= next_lock_loss;
			emphasis    <= next_emphasis;
			irq_enable  <= next_irq_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Lock-lost flag and interrupt status

	// Clears are applied first so that a same-cycle event wins
	always_comb begin
		next_lock_lost_flag = lock_lost_flag;
		next_irq_status     = irq_status;
		if (hit(i_bus, IRQ_CLEAR_ADDR)) begin
			next_irq_status = irq_status & ~i_bus.write_data[IRQ_WIDTH-1:0];
		end
		if (cmd_hit(i_bus, LINK_PLL_LOCK_LOSS_ADDR, LOCK_LOSS_CLEAR_CMD)) begin
			next_lock_lost_flag = 1'b0; // [R04]
		end
		if (lock_lost_event) begin
			next_lock_lost_flag                = 1'b1;
			next_irq_status[IRQ_LOCK_LOST_BIT] = 1'b1;
		end
		if (cmd_hit(i_bus, LINK_PLL_CALIBRATION_ADDR, CALIBRATION_RESET_CMD)) begin
			next_irq_status[IRQ_CAL_RESET_BIT] = 1'b1; // [R02]
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			lock_lost_flag <= 1'b0;
			irq_status     <= '0;
		end else begin
			lock_lost_flag <= next_lock_lost_flag;
			irq_status     <= next_irq_status;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Data stand for one cycle only; write-only and unmapped offsets read zero
	always_comb begin
		next_read_data = 8'h00;
		if (i_bus.read_strobe) begin
			case (i_bus.address)
				LINK_PLL_CALIBRATION_ADDR: next_read_data = calibration;
				LINK_PLL_STARTUP_ADDR:     next_read_data = startup;
				LINK_PLL_LOCK_LOSS_ADDR:   next_read_data = lock_loss;
				LANE3_EMPHASIS_ADDR:       next_read_data = emphasis;
				IRQ_STATUS_ADDR:           next_read_data = {6'h00, irq_status};
				IRQ_ENABLE_ADDR:           next_read_data = {6'h00, irq_enable};
				default:                   next_read_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			read_data <= 8'h00;
		end else begin
			read_data <= next_read_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Decoded from next values so the registered outputs follow the write edge
	function automatic slpd_pll_ctrl_t decode_ctrl(
		input logic [7:0] calibration_value,
		input logic [7:0] startup_value,
		input logic [7:0] lock_loss_value,
		input logic [7:0] emphasis_value
	);
		slpd_pll_ctrl_t ctrl;
		logic [2:0]     field;
		field                  = emphasis_value[EMPHASIS_MSB:EMPHASIS_LSB]; // [R01]
		ctrl.calibration_reset = (calibration_value == CALIBRATION_RESET_CMD); // [R02]
		ctrl.startup_reset     = (startup_value == STARTUP_RESET_CMD); // [R03]
		ctrl.lock_loss_clear   = (lock_loss_value == LOCK_LOSS_CLEAR_CMD); // [R04]
		// Codes above 9 dB are undefined; clamp rather than pass through
		ctrl.emphasis_code     = (field > EMPHASIS_MAX) ?
			EMPHASIS_MAX[1:0] : field[1:0]; // [R01]
		return ctrl;
	endfunction

	slpd_pll_ctrl_t pll_ctrl;
	slpd_pll_ctrl_t next_pll_ctrl;
	logic           irq;
	logic           next_irq;

	always_comb begin
		next_pll_ctrl = decode_ctrl(next_calibration, next_startup, next_lock_loss,
			next_emphasis);
		next_irq      = |(next_irq_status & next_irq_enable);
	end

	// Reset values all decode to zero, so a constant reset is exact
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			pll_ctrl <= '0;
			irq      <= 1'b0;
		end else begin
			pll_ctrl <= next_pll_ctrl;
			irq      <= next_irq;
		end
	end

	assign o_pll_ctrl           = pll_ctrl;
	assign o_read_data          = read_data;
	assign o_pll_lock_lost_flag = lock_lost_flag;
	assign o_irq                = irq;

endmodule
`default_nettype wire

// ---- shared/slpd_pkg.sv ----
// Package for the serial link PLL driver control register bank.
// Assumes a plain address/strobe register port on one 100 MHz clock.
package slpd_pkg;

	localparam int unsigned CLOCK_MHZ = 100;

	// Register offsets
	localparam logic [15:0] LINK_PLL_CALIBRATION_ADDR = 16'h1222;
	localparam logic [15:0] LINK_PLL_STARTUP_ADDR     = 16'h1228;
	localparam logic [15:0] LINK_PLL_LOCK_LOSS_ADDR   = 16'h1262;
	localparam logic [15:0] LANE3_EMPHASIS_ADDR       = 16'h1236;
	localparam logic [15:0] IRQ_STATUS_ADDR           = 16'h1270;
	localparam logic [15:0] IRQ_CLEAR_ADDR            = 16'h1271;
	localparam logic [15:0] IRQ_ENABLE_ADDR           = 16'h1272;

	// Reset values
	localparam logic [7:0] LINK_PLL_CALIBRATION_RESET = 8'h00;
	localparam logic [7:0] LINK_PLL_STARTUP_RESET     = 8'h0f;
	localparam logic [7:0] LINK_PLL_LOCK_LOSS_RESET   = 8'h00;
	localparam logic [7:0] LANE3_EMPHASIS_RESET       = 8'h00;

	// Command values
	localparam logic [7:0] CALIBRATION_RESET_CMD = 8'h04;
	localparam logic [7:0] STARTUP_RESET_CMD     = 8'h4f;
	localparam logic [7:0] STARTUP_NORMAL_CMD    = 8'h00;
	localparam logic [7:0] LOCK_LOSS_CLEAR_CMD   = 8'h80;

	// Emphasis field position
	localparam int unsigned EMPHASIS_LSB = 4;
	localparam int unsigned EMPHASIS_MSB = 6;
	localparam logic [2:0]  EMPHASIS_MAX = 3'h3;

	// Interrupt status bit positions
	localparam int unsigned IRQ_LOCK_LOST_BIT = 0;
	localparam int unsigned IRQ_CAL_RESET_BIT = 1;
	localparam int unsigned IRQ_WIDTH         = 2;

	typedef struct packed {
		logic [15:0] address;
		logic [7:0]  write_data;
		logic        write_strobe;
		logic        read_strobe;
	} slpd_bus_t;

	typedef struct packed {
		logic       calibration_reset;
		logic       startup_reset;
		logic       lock_loss_clear;
		logic [1:0] emphasis_code;
	} slpd_pll_ctrl_t;

endpackage

// ---- test/slpd_regs_monitor.sv ----
// Port checker for the PLL control register bank.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module slpd_regs_monitor
	import slpd_pkg::*;
(
	input wire logic           i_clock,
	input wire logic           i_reset,
	input wire slpd_bus_t      i_bus,
	input wire logic [7:0]     o_read_data,
	input wire logic           i_pll_lock_lost,
	input wire slpd_pll_ctrl_t o_pll_ctrl,
	input wire logic           o_pll_lock_lost_flag,
	input wire logic           o_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	logic [15:0] a;
	logic [7:0]  d;
	logic        w;
	assign a = i_bus.address;
	assign d = i_bus.write_data;
	assign w = i_bus.write_strobe;
	a_read_idle: assert property (!$past(i_bus.read_strobe) |-> o_read_data == 8'h00)
		else $error("read data not idle");
	a_cal_cmd: assert property (w && a == 16'h1222 && d == 8'h04 |=> o_pll_ctrl.calibration_reset)
		else $error("calibration reset missing");
	a_cal_read: assert property (i_bus.read_strobe && a == 16'h1222 &&
		o_pll_ctrl.calibration_reset |=> o_read_data == 8'h04) else $error("calibration readback");
	a_start_cmd: assert property (w && a == 16'h1228 && d == 8'h4f |=> o_pll_ctrl.startup_reset)
		else $error("start-up reset missing");
	a_start_norm: assert property (w && a == 16'h1228 && d != 8'h4f |=> !o_pll_ctrl.startup_reset)
		else $error("start-up reset stuck");
	a_clear_cmd: assert property (w && a == 16'h1262 && d == 8'h80 |=> o_pll_ctrl.lock_loss_clear)
		else $error("lock clear missing");
	a_flag_set: assert property ($rose(i_pll_lock_lost) |-> ##3 o_pll_lock_lost_flag)
		else $error("lock lost flag late");
	a_emph_code: assert property (w && a == 16'h1236 && d[6:4] <= 3'h3 |=>
		o_pll_ctrl.emphasis_code == $past(d[5:4])) else $error("emphasis code wrong");
	a_emph_clamp: assert property (w && a == 16'h1236 && d[6:4] > 3'h3 |=>
		o_pll_ctrl.emphasis_code == 2'h3) else $error("emphasis clamp wrong");
	a_flag_clear: assert property (w && a == 16'h1262 && d == 8'h80 &&
		!($past(i_pll_lock_lost, 2) && !$past(i_pll_lock_lost, 3)) |=> !o_pll_lock_lost_flag)
		else $error("lock lost flag not cleared");
	a_irq_off: assert property (w && a == 16'h1272 && d[1:0] == 2'b00 |=> !o_irq)
		else $error("interrupt while disabled");
	c_cal: cover property (o_pll_ctrl.calibration_reset);
	c_flag: cover property (o_pll_lock_lost_flag);
	c_irq: cover property (o_irq);
endmodule
bind slpd_regs slpd_regs_monitor MON (.i_clock(i_clock), .i_reset(i_reset), .i_bus(i_bus),
	.o_read_data(o_read_data), .i_pll_lock_lost(i_pll_lock_lost), .o_pll_ctrl(o_pll_ctrl),
	.o_pll_lock_lost_flag(o_pll_lock_lost_flag), .o_irq(o_irq));
`default_nettype wire

// ---- test/slpd_pll_model.sv ----
// Link PLL model: reports lock loss as a level on request.
// Assumes the bank synchronises the level itself.
`timescale 1ns/1ps
`default_nettype none
module slpd_pll_model (
	input  wire logic i_clock,
	output logic      o_lock_lost
);
	initial o_lock_lost = 1'b0;
	task automatic lose();
		@(posedge i_clock) o_lock_lost <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_lock_lost <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- test/slpd_regs_tb.sv ----
// Self-checking bench for the PLL control register bank.
// Assumes package, design, checker and PLL model compiled first.
`timescale 1ns/1ps
`default_nettype none
module slpd_regs_tb;
	import slpd_pkg::*;
	logic i_clock = 0, i_reset = 1, lost, flag, irq;
	slpd_bus_t bus = '0;
	slpd_pll_ctrl_t c;
	logic [7:0] rdata, d;
	int miscompares = 0, cmp_count = 0;
	always #5 i_clock = ~i_clock;
	slpd_pll_model PLL (.i_clock(i_clock), .o_lock_lost(lost));
	slpd_regs DUT (.i_clock(i_clock), .i_reset(i_reset), .i_bus(bus), .o_read_data(rdata),
		.i_pll_lock_lost(lost), .o_pll_ctrl(c), .o_pll_lock_lost_flag(flag), .o_irq(irq));
	function automatic logic [7:0] emph(input logic [7:0] v);
		return v[6:4] > 3'h3 ? 8'h03 : 8'(v[5:4]);
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge i_clock) bus <= '{a, v, 1'b1, 1'b0};
		@(posedge i_clock) bus.write_strobe <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_clock) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_clock) bus.read_strobe <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic final_report();
		if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h79790d30));
		repeat (12) @(posedge i_clock);
		i_reset <= 1'b0;
		rd(LINK_PLL_CALIBRATION_ADDR, 8'h00);
		rd(LINK_PLL_STARTUP_ADDR, 8'h0f);
		rd(LINK_PLL_LOCK_LOSS_ADDR, 8'h00);
		rd(LANE3_EMPHASIS_ADDR, 8'h00);
		rd(16'h0000, 8'h00);
		for (int i = 0; i < 12; i++) begin
			d = (i < 8) ? {1'b0, 3'(i), 4'($urandom)} : 8'($urandom);
			wr(LANE3_EMPHASIS_ADDR, d);
			chk(8'(c.emphasis_code), emph(d));
			rd(LANE3_EMPHASIS_ADDR, d);
		end
		wr(LINK_PLL_CALIBRATION_ADDR, 8'h04);
		chk(8'(c.calibration_reset), 8'h01);
		rd(LINK_PLL_CALIBRATION_ADDR, 8'h04);
		wr(LINK_PLL_CALIBRATION_ADDR, 8'h00);
		chk(8'(c.calibration_reset), 8'h00);
		wr(LINK_PLL_STARTUP_ADDR, 8'h4f);
		chk(8'(c.startup_reset), 8'h01);
		rd(LINK_PLL_STARTUP_ADDR, 8'h4f);
		wr(LINK_PLL_STARTUP_ADDR, 8'h00);
		chk(8'(c.startup_reset), 8'h00);
		wr(IRQ_ENABLE_ADDR, 8'h01);
		rd(IRQ_ENABLE_ADDR, 8'h01);
		// Status is read-only; the write must be ignored
		wr(IRQ_STATUS_ADDR, 8'hff);
		rd(IRQ_STATUS_ADDR, 8'h02);
		chk(8'(irq), 8'h00);
		rd(IRQ_CLEAR_ADDR, 8'h00);
		PLL.lose();
		for (int i = 0; i < 20 && flag !== 1'b1; i++) @(posedge i_clock);
		if (flag !== 1'b1) begin
			miscompares++;
		end else begin
			#1 chk(8'(irq), 8'h01);
			rd(IRQ_STATUS_ADDR, 8'h03);
			wr(IRQ_ENABLE_ADDR, 8'h00);
			chk(8'(irq), 8'h00);
			wr(LINK_PLL_LOCK_LOSS_ADDR, 8'h80);
			chk({c.lock_loss_clear, 6'h00, flag}, 8'h80);
			wr(LINK_PLL_LOCK_LOSS_ADDR, 8'h00);
			// Clear lands in the cycle the flag is set: the set must win
			fork
				PLL.lose();
				begin
					repeat (2) @(posedge i_clock);
					wr(LINK_PLL_LOCK_LOSS_ADDR, 8'h80);
				end
			join
			chk({c.lock_loss_clear, 6'h00, flag}, 8'h81);
			wr(LINK_PLL_LOCK_LOSS_ADDR, 8'h80);
			chk(8'(flag), 8'h00);
			wr(LINK_PLL_LOCK_LOSS_ADDR, 8'h00);
			wr(IRQ_CLEAR_ADDR, 8'h03);
			rd(IRQ_STATUS_ADDR, 8'h00);
			// Mid-run reset brings back the reset values
			@(posedge i_clock) i_reset <= 1'b1;
			repeat (2) @(posedge i_clock);
			i_reset <= 1'b0;
			rd(LINK_PLL_STARTUP_ADDR, 8'h0f);
			chk(8'(c.startup_reset), 8'h00);
			rd(LANE3_EMPHASIS_ADDR, 8'h00);
		end
		final_report();
	end
endmodule
`default_nettype wire
